// file: art_pkg.sv
// package: register map, encodings and timing for the auto-retry tx sequencer
package art_pkg;
  // apb register byte offsets
  localparam logic [11:0] ADDR_STATE_CTRL  = 12'h000; // state_control_reg
  localparam logic [11:0] ADDR_STATE_CONTROL_REG   = 12'h004; // transceiver_state_reg
  localparam logic [11:0] ADDR_EXT_CTRL    = 12'h008; // ext_mode_ctrl
  localparam logic [11:0] ADDR_STROBE_PIN  = 12'h00C; // strobe_pin_reg
  localparam logic [11:0] ADDR_IRQ_MASK    = 12'h010; // irq mask
  localparam logic [11:0] ADDR_IRQ_STATUS  = 12'h014; // irq status, write one clear

  // state_control_reg command codes (bits 4:0)
  localparam logic [4:0] CMD_TX_START      = 5'h02;
  localparam logic [4:0] CMD_RADIO_OFF     = 5'h08;
  localparam logic [4:0] CMD_AUTO_ACK_RX   = 5'h16;
  localparam logic [4:0] CMD_AUTO_RETRY_TX = 5'h19;

  // transceiver_state_reg codes
  localparam logic [4:0] ST_RADIO_OFF      = 5'h08;
  localparam logic [4:0] ST_AUTO_ACK_RX    = 5'h16;
  localparam logic [4:0] ST_ART_IDLE       = 5'h19;
  localparam logic [4:0] ST_ART_BUSY       = 5'h12;

  // transaction_result codes
  localparam logic [2:0] RES_SUCCESS       = 3'h0;
  localparam logic [2:0] RES_OK_PENDING    = 3'h1;
  localparam logic [2:0] RES_CHANNEL_BUSY  = 3'h3;
  localparam logic [2:0] RES_NO_ACK        = 3'h5;
  localparam logic [2:0] RES_INVALID       = 3'h7;

  // field positions
  localparam int RESULT_LSB   = 5;   // result in state_control_reg bits 7:5
  localparam int CSMA_LSB     = 1;   // csma_retry_limit in ext_mode_ctrl 3:1
  localparam int FRAME_LSB    = 4;   // frame retry limit in ext_mode_ctrl 7:4
  localparam int ACK_REQ_BIT  = 5;   // ack request bit of first payload octet
  localparam int PEND_BIT     = 4;   // frame pending bit of ack first octet
  localparam logic [2:0] CSMA_NONE = 3'h7;

  // irq bit positions
  localparam int IRQ_LOCK  = 0;
  localparam int IRQ_RXBEG = 2;
  localparam int IRQ_RXEND = 3;
  localparam int IRQ_TXEND = 4;
  localparam int IRQ_AMI   = 5;
  localparam int IRQ_W     = 6;

  // ack wait timing
  localparam int ACK_WAIT_NS  = 864000;
  localparam int CLK_NS       = 4;
  localparam int ACK_WAIT_CYC = ACK_WAIT_NS / CLK_NS; // longest time, rounds down

  // radio-side events gathered together
  typedef struct packed {
    logic cca_done;   // clear channel assessment finished
    logic cca_idle;   // result: channel idle
    logic tx_done;    // frame left the antenna
    logic rx_phr;     // valid phy header
    logic rx_addr_ok; // address filter hit
    logic rx_end;     // frame finished
    logic rx_fcs_ok;  // fcs valid
    logic rx_is_ack;  // frame is an ack of ours
    logic rx_pending; // ack frame pending bit
  } art_radio_s;
endpackage : art_pkg

// file: art_irq_bit.sv
// one sticky interrupt flag with mask gating
`timescale 1ns/100ps
`default_nettype none
module art_irq_bit (
  input  wire logic pclk,    // clock
  input  wire logic presetn, // async reset
  input  wire logic set,     // event pulse
  input  wire logic clr,     // software clear
  input  wire logic mask,    // enable bit
  output logic      flag,    // sticky status
  output logic      irq      // masked output
);
  // set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clr) begin
      flag <= 1'b0;
    end
  end
  // masked request
  assign irq = flag & mask;
endmodule : art_irq_bit
`default_nettype wire

// file: art_sequencer.sv
// auto-retry transmit sequencer with apb registers and extended-mode irqs
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module art_sequencer (
  input  wire logic               pclk,        // 250 mhz clock
  input  wire logic               presetn,     // async reset, active low
  input  wire logic               psel,        // apb select
  input  wire logic               penable,     // apb enable
  input  wire logic               pwrite,      // apb direction
  input  wire logic [11:0]        paddr,       // apb address
  input  wire logic [31:0]        pwdata,      // apb write data
  output logic      [31:0]        prdata,      // apb read data
  output logic                    pready,      // apb ready
  output logic                    pslverr,     // apb error
  input  wire art_pkg::art_radio_s radio,      // radio events
  input  wire logic [7:0]         fb_octet1,   // first payload octet of buffer
  output logic                    cca_start,   // request channel assessment
  output logic                    tx_start,    // request frame transmission
  output logic                    rx_enable,   // receiver on for ack wait or auto-ack receive
  output logic                    ack_tx_done, // own ack sent, one cycle
  output logic                    irq          // combined interrupt
);
  import art_pkg::*;

  typedef enum {S_OFF, S_IDLE, S_AACK, S_CCA, S_TX, S_ACKWAIT} art_state_e;

  art_state_e state;             // sequencer state
  logic [7:0] ext_ctrl;          // ext_mode_ctrl register
  logic [2:0] result;            // transaction_result
  logic [IRQ_W-1:0] irq_mask;    // mask register
  logic [IRQ_W-1:0] irq_flag;    // sticky flags
  logic [IRQ_W-1:0] irq_set;     // event pulses
  logic [IRQ_W-1:0] irq_out;     // masked flags
  logic [2:0] csma_cnt;          // csma attempts used
  logic [3:0] frame_cnt;         // frame attempts used
  logic [17:0] ack_timer;        // ack wait counter
  logic       art_entry;         // entry into auto-retry idle
  logic       off_evt;           // radio off command accepted
  logic       cca_clear;         // channel found idle
  logic       cca_fail;          // channel busy, attempts used up
  logic       cca_again;         // channel busy, try once more
  logic       sent_ack;          // frame sent, ack requested
  logic       sent_only;         // frame sent, no ack requested
  logic       ack_good;          // valid ack received
  logic       ack_late;          // ack wait ran out
  logic       retry_out;         // no frame retries left
  logic       retry_go;          // retry the frame from the channel check
  logic       frame_hit;         // filter hit of the frame in flight
  logic       wr;                // apb write strobe
  logic       rd_ok;             // address mapped
  logic       start_evt;         // transaction start
  logic       done_evt;          // transaction finished
  logic       lock_evt;          // pll lock event
  logic [2:0] csma_lim;          // csma_retry_limit
  logic [3:0] frame_lim;         // frame retry limit

  // retry limits from ext_mode_ctrl
  assign csma_lim  = ext_ctrl[CSMA_LSB +: 3];
  assign frame_lim = ext_ctrl[FRAME_LSB +: 4];

  // apb: zero wait states
  assign pready = 1'b1;
  assign wr     = psel & penable & pwrite;

  // address decode
  always_comb begin
    rd_ok  = 1'b1;
    prdata = 32'h0000_0000;
    unique case (paddr)
      ADDR_STATE_CTRL: prdata[7:0] = {result, 5'h00};
      ADDR_STATE_CONTROL_REG: begin
        unique case (state)
          S_OFF:   prdata[4:0] = ST_RADIO_OFF;
          S_IDLE:  prdata[4:0] = ST_ART_IDLE;
          S_AACK:  prdata[4:0] = ST_AUTO_ACK_RX;
          default: prdata[4:0] = ST_ART_BUSY;
        endcase
      end
      ADDR_EXT_CTRL:   prdata[7:0] = ext_ctrl;
      ADDR_STROBE_PIN: prdata = 32'h0000_0000;
      ADDR_IRQ_MASK:   prdata[IRQ_W-1:0] = irq_mask;
      ADDR_IRQ_STATUS: prdata[IRQ_W-1:0] = irq_flag;
      default:         rd_ok = 1'b0;
    endcase
  end
  // unmapped address answers with an error
  assign pslverr = psel & penable & ~rd_ok;

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_ctrl <= 8'h00;
      irq_mask <= '0;
    end else if (wr) begin
      if (paddr == ADDR_EXT_CTRL) begin
        ext_ctrl <= pwdata[7:0];
      end
      if (paddr == ADDR_IRQ_MASK) begin
        irq_mask <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // start from strobe bit or tx command
  assign start_evt = wr && (state == S_IDLE) &&
                     ((paddr == ADDR_STROBE_PIN && pwdata[0]) ||
                      (paddr == ADDR_STATE_CTRL && pwdata[4:0] == CMD_TX_START));
  assign lock_evt  = wr && (state == S_OFF) && (paddr == ADDR_STATE_CTRL) &&
                     (pwdata[4:0] == CMD_AUTO_RETRY_TX ||
                      pwdata[4:0] == CMD_AUTO_ACK_RX);

  // mode entry command from off
  assign art_entry = lock_evt && (pwdata[4:0] == CMD_AUTO_RETRY_TX);
  // radio off accepted from either idle mode
  assign off_evt   = wr && (paddr == ADDR_STATE_CTRL) && (pwdata[4:0] == CMD_RADIO_OFF) &&
                     ((state == S_IDLE) || (state == S_AACK));

  // channel check outcomes, taken only on the done pulse
  assign cca_clear = (state == S_CCA) && radio.cca_done && radio.cca_idle;
  assign cca_fail  = (state == S_CCA) && radio.cca_done && !radio.cca_idle &&
                     (csma_cnt >= csma_lim);
  assign cca_again = (state == S_CCA) && radio.cca_done && !radio.cca_idle &&
                     (csma_cnt < csma_lim);

  // end of the frame on air, split by the ack request bit
  assign sent_ack  = (state == S_TX) && radio.tx_done && fb_octet1[ACK_REQ_BIT];
  assign sent_only = (state == S_TX) && radio.tx_done && !fb_octet1[ACK_REQ_BIT];

  // ack wait outcomes; a good ack beats the timeout in the same cycle
  assign ack_good  = (state == S_ACKWAIT) && radio.rx_end && radio.rx_is_ack &&
                     radio.rx_fcs_ok;
  assign ack_late  = (state == S_ACKWAIT) && !ack_good &&
                     (ack_timer == 18'(ACK_WAIT_CYC - 1));
  // csma disabled means a single attempt
  assign retry_out = ack_late &&
                     ((csma_lim == CSMA_NONE) || (frame_cnt >= frame_lim));
  assign retry_go  = ack_late && !retry_out;

  // sequencer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_OFF;
    end else begin
      unique case (state)
        // radio off: waits for a mode command
        S_OFF: begin
          // mode command picks the target state
          if (art_entry) begin
            state <= S_IDLE;
          end else if (lock_evt) begin
            state <= S_AACK;
          end
        end
        // auto-retry idle: waits for a start
        S_IDLE: begin
          if (start_evt) begin
            // immediate send when csma is disabled
            state <= (csma_lim == CSMA_NONE) ? S_TX : S_CCA;
          end else if (off_evt) begin
            state <= S_OFF;
          end
        end
        // auto-ack receive: left only by radio off
        S_AACK: begin
          if (off_evt) begin
            state <= S_OFF;
          end
        end
        // channel check running
        S_CCA: begin
          // busy with attempts left: stay and count
          if (cca_clear) begin
            state <= S_TX;
          end else if (cca_fail) begin
            state <= S_IDLE;
          end
        end
        // frame on air
        S_TX: begin
          if (sent_ack) begin
            state <= S_ACKWAIT;
          end else if (sent_only) begin
            state <= S_IDLE;
          end
        end
        // receiver on, waiting for the ack
        S_ACKWAIT: begin
          // foreign frames are ignored here
          if (ack_good || retry_out) begin
            state <= S_IDLE;
          end else if (retry_go) begin
            state <= S_CCA;
          end
        end
        // unreachable codes fall back to off
        default: begin
          state <= S_OFF;
        end
      endcase
    end
  end

  // transaction_result, one write per outcome
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result <= RES_INVALID;
    end else if (art_entry) begin
      // entering the mode invalidates the old outcome
      result <= RES_INVALID;
    end else if (cca_fail) begin
      // channel never found clear
      result <= RES_CHANNEL_BUSY;
    end else if (sent_only) begin
      // no ack asked: sending is success
      result <= RES_SUCCESS;
    end else if (ack_good) begin
      // pending bit of the ack selects the code
      result <= radio.rx_pending ? RES_OK_PENDING : RES_SUCCESS;
    end else if (retry_out) begin
      result <= RES_NO_ACK;
    end
  end

  // one completion pulse per transaction, never per attempt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_evt <= 1'b0;
    end else begin
      done_evt <= cca_fail | sent_only | ack_good | retry_out;
    end
  end

  // csma attempts of the current frame attempt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csma_cnt <= 3'h0;
    end else if (start_evt || retry_go) begin
      // fresh count for every transaction and retry
      csma_cnt <= 3'h0;
    end else if (cca_again) begin
      csma_cnt <= csma_cnt + 3'h1;
    end
  end

  // frame retries of the current transaction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_cnt <= 4'h0;
    end else if (start_evt) begin
      frame_cnt <= 4'h0;
    end else if (retry_go) begin
      frame_cnt <= frame_cnt + 4'h1;
    end
  end

  // ack wait timer, restarted at each send that asks for an ack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_timer <= '0;
    end else if (sent_ack) begin
      ack_timer <= '0;
    end else if (state == S_ACKWAIT) begin
      ack_timer <= ack_timer + 18'h1;
    end
  end

  // address filter hit of the frame in flight, dropped at its end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_hit <= 1'b0;
    end else if ((state != S_AACK) || radio.rx_end) begin
      frame_hit <= 1'b0;
    end else if (radio.rx_phr) begin
      // a new header starts a new frame
      frame_hit <= radio.rx_addr_ok;
    end else if (radio.rx_addr_ok) begin
      frame_hit <= 1'b1;
    end
  end

  // radio requests, decoded from the state alone
  assign cca_start   = (state == S_CCA);
  assign tx_start    = (state == S_TX);
  assign rx_enable   = (state == S_ACKWAIT) || (state == S_AACK);
  // own ack transmit end in auto-ack mode
  assign ack_tx_done = (state == S_AACK) & radio.tx_done;

  // interrupt event sources
  always_comb begin
    irq_set            = '0;
    // pll lock on entry from off
    irq_set[IRQ_LOCK]  = lock_evt;
    // end of a whole transaction, or of our own ack
    irq_set[IRQ_TXEND] = done_evt | ack_tx_done;
    // ack frames never raise receive events
    irq_set[IRQ_RXBEG] = (state == S_AACK) & radio.rx_phr & ~radio.rx_is_ack;
    irq_set[IRQ_AMI]   = (state == S_AACK) & radio.rx_addr_ok & ~radio.rx_is_ack;
    // receive end only for a filtered frame with good fcs
    irq_set[IRQ_RXEND] = (state == S_AACK) & radio.rx_end & (frame_hit | radio.rx_addr_ok) &
                         radio.rx_fcs_ok & ~radio.rx_is_ack;
    // bit 1 has no source here
    irq_set[1]         = 1'b0;
  end

  // sticky flags, write one to clear
  genvar g;
  generate
    for (g = 0; g < IRQ_W; g++) begin : g_irq
      art_irq_bit u_bit (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (irq_set[g]),
        .clr     (wr && paddr == ADDR_IRQ_STATUS && pwdata[g]),
        .mask    (irq_mask[g]),
        .flag    (irq_flag[g]),
        .irq     (irq_out[g])
      );
    end
  endgenerate

  assign irq = |irq_out;
endmodule : art_sequencer
`default_nettype wire

// file: art_props.sv
// checker: port-level timing properties of the auto-retry sequencer
`timescale 1ns/100ps
`default_nettype none
module art_props
  import art_pkg::*;
(
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire art_pkg::art_radio_s radio,
  input wire logic [7:0]       fb_octet1,
  input wire logic             cca_start,
  input wire logic             tx_start,
  input wire logic             rx_enable,
  input wire logic             ack_tx_done,
  input wire logic             irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // idle channel hands over to the send
  property p_go; cca_start && radio.cca_done && radio.cca_idle |=> tx_start && !cca_start; endproperty
  a_go: assert property (p_go) else $error("no send after idle channel");
  // busy channel never sends
  property p_hold; cca_start && radio.cca_done && !radio.cca_idle |=> !tx_start; endproperty
  a_hold: assert property (p_hold) else $error("send on busy channel");
  // ack request bit opens the receiver
  property p_listen;
    tx_start && radio.tx_done && fb_octet1[ACK_REQ_BIT] |=> rx_enable && !tx_start;
  endproperty
  a_listen: assert property (p_listen) else $error("no ack wait after send");
  // no ack request: done at once
  property p_nolisten;
    tx_start && radio.tx_done && !fb_octet1[ACK_REQ_BIT] |=> !rx_enable && !cca_start;
  endproperty
  a_nolisten: assert property (p_nolisten) else $error("waits for ack not asked");
  // foreign frames keep the wait going
  property p_discard; rx_enable && radio.rx_end && !radio.rx_is_ack |=> rx_enable; endproperty
  a_discard: assert property (p_discard) else $error("wait ended by foreign frame");
  // a send never overlaps a check or a listen
  property p_excl; !(cca_start && tx_start) && !(tx_start && rx_enable); endproperty
  a_excl: assert property (p_excl) else $error("radio requests overlap");
  // access above the irq status address flagged in the access phase
  property p_err; psel && penable && (paddr > ADDR_IRQ_STATUS) |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("unmapped access not flagged");
  // every access completes at once
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready missing");
endmodule : art_props
bind art_sequencer art_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .radio(radio), .fb_octet1(fb_octet1),
  .cca_start(cca_start), .tx_start(tx_start), .rx_enable(rx_enable),
  .ack_tx_done(ack_tx_done), .irq(irq));
`default_nettype wire

// file: art_air_model.sv
// partner: air-side peer answering channel checks, sends and ack waits
`timescale 1ns/100ps
`default_nettype none
module art_air_model
  import art_pkg::*;
(
  input  wire logic       pclk,      // clock
  input  wire logic       presetn,   // reset
  input  wire logic       cca_start, // channel check wanted
  input  wire logic       tx_start,  // frame on air
  input  wire logic       rx_enable, // receiver listening
  input  wire logic       clr,       // restart attempt count
  input  wire logic [3:0] busy_n,    // busy answers before idle
  input  wire logic [1:0] ack_mode,  // 0 none, 1 ack, 2 pending, 3 foreign first
  input  wire art_radio_s rx_req,    // frame events from bench
  output art_radio_s      radio,     // events to the sequencer
  output logic      [3:0] cca_cnt    // channel checks answered
);
  logic [1:0] cnt;  // answer delay
  logic       junk; // foreign frame already sent
  // answer on every fourth cycle while any request stays up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      radio   <= '0;
      cnt     <= '0;
      cca_cnt <= '0;
      junk    <= 1'b0;
    end else begin
      radio            <= rx_req;
      radio.cca_idle   <= ~radio.cca_idle;   // level wanders outside answers
      radio.rx_pending <= ~radio.rx_pending;
      // frame qualifiers hold still with every frame event
      if (!(rx_req.rx_end || rx_req.rx_phr || rx_req.rx_addr_ok)) begin
        radio.rx_fcs_ok <= ~radio.rx_fcs_ok;
        radio.rx_is_ack <= ~radio.rx_is_ack;
      end
      cnt <= (cca_start || tx_start || rx_enable) ? cnt + 2'd1 : 2'd0;
      if (clr) begin
        cca_cnt <= '0;
        junk    <= 1'b0;
      end
      if (cnt == 2'd3) begin
        if (cca_start) begin
          radio.cca_done <= 1'b1;
          radio.cca_idle <= (cca_cnt >= busy_n);
          cca_cnt        <= cca_cnt + 4'd1;
        end else if (tx_start) begin
          radio.tx_done <= 1'b1;
        end else if (rx_enable && ack_mode != 2'd0) begin
          radio.rx_end     <= 1'b1;
          radio.rx_fcs_ok  <= 1'b1;
          radio.rx_is_ack  <= (ack_mode != 2'd3) || junk;
          radio.rx_pending <= (ack_mode == 2'd2);
          junk             <= 1'b1;
        end
      end
    end
  end
endmodule : art_air_model
`default_nettype wire

// file: art_sequencer_tb_top.sv
// testbench: apb-driven transactions against the air-side model
`timescale 1ns/100ps
`default_nettype none
module art_sequencer_tb_top;
  import art_pkg::*;
  typedef struct packed {
    logic [7:0] ext; logic [7:0] oct; logic [3:0] busy;
    logic [1:0] ack; logic cmd; logic [2:0] res; logic [3:0] ncca;
  } art_case_s;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, clr = 0, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic pready, pslverr, cca_start, tx_start, rx_enable, irq, ack_done;
  logic [7:0] fb = 8'h00;
  logic [3:0] busy_n = '0, cca_cnt;
  logic [1:0] ack_mode = '0;
  art_radio_s radio, rx_req = '0;
  int bad_count = 0, cmp_count = 0, cyc = 0, n;
  // ext, octet, busy, ack, by command, result, channel checks
  art_case_s tc[6] = '{'{8'h14, 8'h20, 4'h2, 2'h1, 1'b0, 3'h0, 4'h3},
    '{8'h14, 8'h20, 4'h0, 2'h2, 1'b1, 3'h1, 4'h1}, '{8'h14, 8'h00, 4'h1, 2'h0, 1'b0, 3'h0, 4'h2},
    '{8'h14, 8'h20, 4'h3, 2'h1, 1'b1, 3'h3, 4'h3}, '{8'h14, 8'h20, 4'h2, 2'h3, 1'b0, 3'h0, 4'h3},
    '{8'h1E, 8'h20, 4'h5, 2'h1, 1'b1, 3'h0, 4'h0}};
  art_radio_s fa[3] = '{9'h030, 9'h030, 9'h022}; // header events
  art_radio_s fe[3] = '{9'h00C, 9'h008, 9'h00E}; // end events
  logic [31:0] fx[3] = '{32'h2C, 32'h24, 32'h00}; // flags expected
  art_sequencer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .radio(radio), .fb_octet1(fb), .cca_start(cca_start),
    .tx_start(tx_start), .rx_enable(rx_enable), .ack_tx_done(ack_done), .irq(irq));
  art_air_model air (.pclk(pclk), .presetn(presetn), .cca_start(cca_start),
    .tx_start(tx_start), .rx_enable(rx_enable), .clr(clr), .busy_n(busy_n),
    .ack_mode(ack_mode), .rx_req(rx_req), .radio(radio), .cca_cnt(cca_cnt));
  // 250 mhz clock
  initial begin
    forever #2 pclk = ~pclk;
  end
  // verdict and end of run
  task finish_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one apb transfer, result in q and err
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task inject(input art_radio_s v);
    @(posedge pclk);
    rx_req <= v;
    @(posedge pclk);
    rx_req <= '0;
  endtask : inject
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, ADDR_STATE_CONTROL_REG, 0);
    chk("state", q, ST_RADIO_OFF);
    apb(0, ADDR_STATE_CTRL, 0);
    chk("result", q[7:5], RES_INVALID);
    apb(1, ADDR_IRQ_MASK, 32'h3F);
    apb(1, ADDR_STATE_CTRL, CMD_AUTO_RETRY_TX);
    apb(0, ADDR_STATE_CTRL, 0);
    chk("result", q[7:5], RES_INVALID);
    apb(0, ADDR_IRQ_STATUS, 0);
    chk("flags", q, 32'h01);
    apb(1, ADDR_IRQ_STATUS, 32'h3F);
    apb(0, 12'h020, 0);
    chk("slverr", err, 1);
    for (int i = 0; i < 6; i++) begin
      clr <= 1'b1;
      fb <= tc[i].oct;
      {busy_n, ack_mode} <= {tc[i].busy, tc[i].ack};
      apb(1, ADDR_EXT_CTRL, tc[i].ext);
      clr <= 1'b0;
      apb(1, tc[i].cmd ? ADDR_STATE_CTRL : ADDR_STROBE_PIN, tc[i].cmd ? CMD_TX_START : 1);
      apb(0, ADDR_STATE_CONTROL_REG, 0);
      chk("busy", q, ST_ART_BUSY);
      n = 0;
      while (irq !== 1'b1 && n < 3000) begin
        @(posedge pclk);
        n++;
      end
      chk("tx irq", irq, 1);
      apb(0, ADDR_IRQ_STATUS, 0);
      chk("flags", q, 32'h10);
      apb(0, ADDR_STATE_CONTROL_REG, 0);
      chk("idle", q, ST_ART_IDLE);
      apb(0, ADDR_STATE_CTRL, 0);
      chk("result", q[7:5], tc[i].res);
      chk("checks", cca_cnt, tc[i].ncca);
      apb(1, ADDR_IRQ_STATUS, 32'h3F);
      $display("case %0d done", i);
    end
    ack_mode <= 2'h0;
    apb(1, ADDR_IRQ_MASK, 0);
    apb(1, ADDR_STATE_CTRL, CMD_RADIO_OFF);
    apb(1, ADDR_STATE_CTRL, CMD_AUTO_ACK_RX);
    apb(0, ADDR_IRQ_STATUS, 0);
    chk("flags", q, 32'h01);
    apb(1, ADDR_IRQ_STATUS, 32'h3F);
    for (int j = 0; j < 3; j++) begin
      inject(fa[j]);
      inject(fe[j]);
      apb(0, ADDR_IRQ_STATUS, 0);
      chk("rx flags", q, fx[j]);
      chk("masked", irq, 0);
      if (j < 2) apb(1, ADDR_IRQ_STATUS, 32'h3F);
    end
    apb(1, ADDR_IRQ_MASK, 32'h08);
    @(posedge pclk);
    chk("unmasked", irq, 0);
    inject(fa[0]);
    inject(fe[0]);
    repeat (2) @(posedge pclk);
    chk("unmasked", irq, 1);
    apb(1, ADDR_IRQ_STATUS, 32'h3F);
    inject(9'h040);
    @(negedge pclk);
    chk("ack done", ack_done, 1);
    apb(0, ADDR_IRQ_STATUS, 0);
    chk("ack flag", q, 32'h10);
    $display("receive checks done");
    finish_test();
  end
endmodule : art_sequencer_tb_top
`default_nettype wire
